// ### pkg/loop_pkg.sv
// Constants and types shared by the block-repeat logic
package loop_pkg;
   // ******************************
   // Encodings
   // ******************************
   localparam logic [15:0] OP_SAVE = 16'hfff0;
   localparam logic [15:0] OP_RESTORE = 16'hfff1;
   localparam logic [15:0] RPT_MASK = 16'hff80;
   localparam logic [15:0] RPT_PATTERN = 16'hb500;
   localparam logic [15:0] OPERAND_MASK = 16'hff00;
   // ******************************
   // Field layout and widths
   // ******************************
   localparam int SIZE_W = 7;
   localparam int CNT_W = 16;
   localparam int LOC_W = 8;
   localparam int RPT_WORDS = 2;
   localparam int RPT_CYCLES = 4;
   // Saved word: {size, count, start, shadow, active}
   localparam int ACTIVE_OFS = 0;
   localparam int SHADOW_OFS = 1;
   // ******************************
   // Reset values
   // ******************************
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [SIZE_W-1:0] SIZE_RST = 7'h00;
   typedef enum logic [1:0] {ST_IDLE, ST_OPERAND, ST_FETCH, ST_LOAD} rpt_state_t;
endpackage : loop_pkg

// ### src/block_repeat.sv
// Zero-overhead block-repeat controller with loop-state save, restore and shadow
`timescale 1ns/10ps
// What this block does
// - Word fff1 reloads the loop state from the stack.
// - Word fff0 writes the loop state onto the stack.
// - Save and restore each finish in one cycle.
// - Repeat is two words: b5 prefix plus size, then zero byte plus location.
// - Repeat count is a 16-bit value read from the operand location.
// - Count N gives N+1 passes of the block.
// - Repeat costs four cycles first pass, zero thereafter.
// - These three instructions leave all vector status flags unchanged.
// - Interrupt entry copies loop active into the shadow bit.
// - Interrupt entry then clears loop active.
// - Interrupt return copies shadow into active, then clears shadow.
// - Loop active clears when the final pass reaches the end label.
module block_repeat
   import loop_pkg::*;
#(
   parameter int ADDR_W = 22
)
(
   input wire logic I_CLOCK,
   input wire logic I_NRST,
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr_word,
   input wire logic [ADDR_W-1:0] i_instr_addr,
   input wire logic [CNT_W-1:0] i_cnt_data,
   input wire logic i_fetch_valid,
   input wire logic [ADDR_W-1:0] i_fetch_addr,
   input wire logic i_int_taken,
   input wire logic i_int_return,
   input wire logic [2+SIZE_W+CNT_W+ADDR_W-1:0] i_pop_data,
   output logic o_stall,
   output logic o_flags_hold,
   output logic o_cnt_req,
   output logic [LOC_W-1:0] o_cnt_loc,
   output logic o_push_valid,
   output logic [2+SIZE_W+CNT_W+ADDR_W-1:0] o_push_data,
   output logic o_pop_req,
   output logic o_redirect,
   output logic [ADDR_W-1:0] o_redirect_addr,
   output logic o_loop_active,
   output logic o_loop_shadow,
   output logic [CNT_W-1:0] o_remaining
);
   localparam int STATE_W = 2 + SIZE_W + CNT_W + ADDR_W;
   localparam int CNT_OFS = ADDR_W;
   localparam int SIZE_OFS = ADDR_W + CNT_W;

   generate
      if (ADDR_W < SIZE_W + 1 || ADDR_W > 32)
      begin : g_bad_addr
         $error("block_repeat: ADDR_W out of range");
      end
   endgenerate

   // ******************************
   // Decode
   // ******************************
   logic dec_save;
   logic dec_restore;
   logic dec_rpt;
   logic dec_operand_ok;
   logic [SIZE_W-1:0] dec_size;
   logic [LOC_W-1:0] dec_loc;

   repeat_decode u_decode (
      .i_word(i_instr_word),
      .o_is_save(dec_save),
      .o_is_restore(dec_restore),
      .o_is_rpt(dec_rpt),
      .o_operand_ok(dec_operand_ok),
      .o_size(dec_size),
      .o_loc(dec_loc)
   );

   // ******************************
   // State
   // ******************************
   rpt_state_t state_reg, state_next;
   logic active_reg, active_next;
   logic shadow_reg, shadow_next;
   logic [SIZE_W-1:0] size_reg, size_next;
   logic [CNT_W-1:0] count_reg, count_next;
   logic [ADDR_W-1:0] start_reg, start_next;
   logic [LOC_W-1:0] loc_reg, loc_next;

   logic in_idle;
   logic do_save;
   logic do_restore;
   logic at_end;
   logic [ADDR_W-1:0] end_addr;

   assign in_idle = (state_reg == ST_IDLE);
   assign do_save = in_idle && i_instr_valid && dec_save;
   assign do_restore = in_idle && i_instr_valid && dec_restore;
   // End label sits right after the last block word
   assign end_addr = start_reg + ADDR_W'(size_reg);
   assign at_end = active_reg && i_fetch_valid && (i_fetch_addr == end_addr);

   always_comb
   begin
      state_next = state_reg;
      active_next = active_reg;
      shadow_next = shadow_reg;
      size_next = size_reg;
      count_next = count_reg;
      start_next = start_reg;
      loc_next = loc_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (i_instr_valid && dec_rpt)
            begin
               state_next = ST_OPERAND;
               size_next = dec_size;
               start_next = i_instr_addr + ADDR_W'(RPT_WORDS);
            end
         end
         ST_OPERAND:
         begin
            // A malformed second word abandons the repeat quietly
            if (i_instr_valid)
            begin
               state_next = dec_operand_ok ? ST_FETCH : ST_IDLE;
               loc_next = dec_loc;
            end
         end
         ST_FETCH:
            state_next = ST_LOAD;
         ST_LOAD:
         begin
            // A new repeat simply replaces any loop in flight
            state_next = ST_IDLE;
            count_next = i_cnt_data;
            active_next = 1'h1;
         end
         default:
            state_next = ST_IDLE;
      endcase
      // Loop end outranks nothing the core does in the same cycle
      if (at_end && state_reg != ST_LOAD)
      begin
         if (count_reg != CNT_RST)
            count_next = count_reg - CNT_W'(1);
         else
            active_next = 1'h0;
      end
      if (i_int_return)
      begin
         active_next = shadow_reg;
         shadow_next = 1'h0;
      end
      if (i_int_taken)
      begin
         shadow_next = active_next;
         active_next = 1'h0;
      end
      // Restore wins: software has interrupts masked around it
      if (do_restore)
      begin
         active_next = i_pop_data[ACTIVE_OFS];
         shadow_next = i_pop_data[SHADOW_OFS];
         start_next = i_pop_data[2 +: ADDR_W];
         count_next = i_pop_data[2+CNT_OFS +: CNT_W];
         size_next = i_pop_data[2+SIZE_OFS +: SIZE_W];
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         state_reg <= ST_IDLE;
         active_reg <= 1'h0;
         shadow_reg <= 1'h0;
         size_reg <= SIZE_RST;
         count_reg <= CNT_RST;
         start_reg <= '0;
         loc_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         active_reg <= active_next;
         shadow_reg <= shadow_next;
         size_reg <= size_next;
         count_reg <= count_next;
         start_reg <= start_next;
         loc_reg <= loc_next;
      end
   end

   // ******************************
   // Outputs
   // ******************************
   assign o_stall = (state_reg == ST_FETCH) || (state_reg == ST_LOAD);
   assign o_cnt_req = (state_reg == ST_FETCH);
   assign o_cnt_loc = loc_reg;
   assign o_push_valid = do_save;
   assign o_push_data = {size_reg, count_reg, start_reg, shadow_reg, active_reg};
   assign o_pop_req = do_restore;
   // Status flags are never written by repeat, save or restore
   assign o_flags_hold = do_save || do_restore || !in_idle
      || (i_instr_valid && dec_rpt);
   assign o_redirect = at_end && (count_reg != CNT_RST) && state_reg != ST_LOAD;
   assign o_redirect_addr = start_reg;
   assign o_loop_active = active_reg;
   assign o_loop_shadow = shadow_reg;
   assign o_remaining = count_reg;

   // ******************************
   // Checks
   // ******************************
   logic quiet;
   assign quiet = !i_int_taken && !i_int_return && !do_restore;

   chk_save_pulse: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      in_idle && i_instr_valid && i_instr_word == 16'hfff0 |-> o_push_valid && !o_stall)
      else $error("save word not pushed in one cycle");
   chk_restore_load: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      o_pop_req |=> active_reg == $past(i_pop_data[0]) && state_reg == ST_IDLE)
      else $error("restore did not reload loop state");
   chk_repeat_timing: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      state_reg == ST_OPERAND && i_instr_valid && dec_operand_ok
      |=> o_cnt_req ##1 o_stall && !o_cnt_req ##1 in_idle)
      else $error("repeat setup not four cycles");
   chk_count_load: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      state_reg == ST_LOAD && quiet |=> active_reg && count_reg == $past(i_cnt_data))
      else $error("count not loaded");
   chk_jump_back: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      at_end && count_reg != 16'h0000 && in_idle && quiet
      |-> o_redirect ##1 count_reg == $past(count_reg) - 16'h0001 && active_reg)
      else $error("block end did not jump back");
   chk_final_pass: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      at_end && count_reg == 16'h0000 && in_idle && quiet |-> !o_redirect ##1 !active_reg)
      else $error("final pass did not end loop");
   chk_int_entry: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      i_int_taken && !i_int_return && !do_restore && !at_end && in_idle
      |=> shadow_reg == $past(active_reg) && !active_reg)
      else $error("interrupt entry shadow wrong");
   chk_int_exit: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      i_int_return && !i_int_taken && !do_restore |=> active_reg == $past(shadow_reg)
      && !shadow_reg)
      else $error("interrupt return shadow wrong");
   chk_flag_hold: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      in_idle && i_instr_valid && (i_instr_word & RPT_MASK) == RPT_PATTERN
      |-> o_flags_hold ##1 o_flags_hold)
      else $error("flags not held during repeat");

   cov_full_loop: cover property (@(posedge I_CLOCK) disable iff (!I_NRST)
      o_redirect ##[1:200] (at_end && count_reg == 16'h0000));
   cov_int_nested: cover property (@(posedge I_CLOCK) disable iff (!I_NRST)
      (i_int_taken && active_reg) ##[1:100] i_int_return);
   cov_save_restore: cover property (@(posedge I_CLOCK) disable iff (!I_NRST)
      o_push_valid ##[1:50] o_pop_req);
endmodule : block_repeat

// ### src/repeat_decode.sv
// Opcode decoder for the block-repeat and loop-state save/restore words
`timescale 1ns/10ps
module repeat_decode
   import loop_pkg::*;
(
   input wire logic [15:0] i_word,
   output logic o_is_save,
   output logic o_is_restore,
   output logic o_is_rpt,
   output logic o_operand_ok,
   output logic [SIZE_W-1:0] o_size,
   output logic [LOC_W-1:0] o_loc
);
   assign o_is_save = (i_word == OP_SAVE);
   assign o_is_restore = (i_word == OP_RESTORE);
   assign o_is_rpt = ((i_word & RPT_MASK) == RPT_PATTERN);
   assign o_operand_ok = ((i_word & OPERAND_MASK) == 16'h0000);
   assign o_size = i_word[SIZE_W-1:0];
   assign o_loc = i_word[LOC_W-1:0];
endmodule : repeat_decode

// ### tb/host_model.sv
// Host-side model: count memory and loop-state stack
`timescale 1ns/10ps
module host_model
   import loop_pkg::*;
#(
   parameter int ADDR_W = 22
)
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_cnt_req,
   input wire logic [LOC_W-1:0] i_cnt_loc,
   input wire logic i_push_valid,
   input wire logic [2+SIZE_W+CNT_W+ADDR_W-1:0] i_push_data,
   input wire logic i_pop_req,
   output logic [CNT_W-1:0] o_cnt_data,
   output logic [2+SIZE_W+CNT_W+ADDR_W-1:0] o_pop_data
);
   logic [2+SIZE_W+CNT_W+ADDR_W-1:0] stack_mem [0:3];
   logic [1:0] depth;
   assign o_pop_data = stack_mem[depth-2'h1];
   // Location L holds count L; outside a read the bus toggles so stale data never matches
   always @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         o_cnt_data <= 16'hffff;
      else if (i_cnt_req)
         o_cnt_data <= {8'h00, i_cnt_loc};
      else
         o_cnt_data <= ~o_cnt_data;
   end
   always @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         depth <= 2'h0;
      else if (i_push_valid)
      begin
         stack_mem[depth] <= i_push_data;
         depth <= depth + 2'h1;
      end
      else if (i_pop_req)
         depth <= depth - 2'h1;
   end
endmodule : host_model

// ### tb/testbench.sv
// Self-checking bench for the block-repeat controller
`timescale 1ns/10ps
module testbench;
   import loop_pkg::*;
   typedef struct {logic v; logic [15:0] w; logic push; logic pop; logic hold;} row_t;
   localparam int AW = 22;
   localparam int SW = 2+SIZE_W+CNT_W+AW;
   logic clock = 1'h0;
   logic nrst = 1'h0;
   logic instr_valid = 1'h0;
   logic [15:0] instr_word = 16'h0000;
   logic [AW-1:0] instr_addr = 22'h0;
   logic fetch_valid = 1'h0;
   logic [AW-1:0] fetch_addr = 22'h0;
   logic int_taken = 1'h0;
   logic int_return = 1'h0;
   logic [CNT_W-1:0] cnt_data, remaining;
   logic [SW-1:0] pop_data, push_data;
   logic stall, flags_hold, cnt_req, push_valid, pop_req, redirect, loop_active, loop_shadow;
   logic [LOC_W-1:0] cnt_loc;
   logic [AW-1:0] redirect_addr;
   int mismatches = 0;
   int tests_run = 0;
   row_t rows [5] = '{'{1'h1, OP_SAVE, 1'h1, 1'h0, 1'h1}, '{1'h1, OP_RESTORE, 1'h0, 1'h1, 1'h1},
      '{1'h1, 16'hfff2, 1'h0, 1'h0, 1'h0}, '{1'h1, 16'hb4ff, 1'h0, 1'h0, 1'h0},
      '{1'h0, OP_SAVE, 1'h0, 1'h0, 1'h0}};
   always #5 clock = ~clock;
   block_repeat #(.ADDR_W(AW)) i_block_repeat (.I_CLOCK(clock), .I_NRST(nrst),
      .i_instr_valid(instr_valid), .i_instr_word(instr_word), .i_instr_addr(instr_addr),
      .i_cnt_data(cnt_data), .i_fetch_valid(fetch_valid), .i_fetch_addr(fetch_addr),
      .i_int_taken(int_taken), .i_int_return(int_return), .i_pop_data(pop_data),
      .o_stall(stall), .o_flags_hold(flags_hold), .o_cnt_req(cnt_req), .o_cnt_loc(cnt_loc),
      .o_push_valid(push_valid), .o_push_data(push_data), .o_pop_req(pop_req),
      .o_redirect(redirect), .o_redirect_addr(redirect_addr), .o_loop_active(loop_active),
      .o_loop_shadow(loop_shadow), .o_remaining(remaining));
   host_model #(.ADDR_W(AW)) i_host_model (.i_clock(clock), .i_nrst(nrst), .i_cnt_req(cnt_req),
      .i_cnt_loc(cnt_loc), .i_push_valid(push_valid), .i_push_data(push_data),
      .i_pop_req(pop_req), .o_cnt_data(cnt_data), .o_pop_data(pop_data));
   // ******************************
   // Tasks
   // ******************************
   task automatic check_flag(input logic got, input logic exp);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_flag
   task automatic check_vec(input logic [SW-1:0] got, input logic [SW-1:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_vec
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   task automatic drive(input logic v, input logic [15:0] w, input logic [AW-1:0] a);
      @(negedge clock);
      instr_valid = v;
      instr_word = w;
      instr_addr = a;
      #1;
   endtask : drive
   task automatic pulse(input logic ret);
      @(negedge clock);
      int_taken = !ret;
      int_return = ret;
      @(negedge clock);
      int_taken = 1'h0;
      int_return = 1'h0;
      #1;
   endtask : pulse
   // Size stands for the words from block start to the end label
   task automatic start_loop(input logic [AW-1:0] a, input logic [6:0] size, input logic [7:0] loc);
      drive(1'h1, {9'h16a, size}, a);
      check_flag(flags_hold, 1'h1);
      drive(1'h1, {8'h00, loc}, a + 22'h1);
      drive(1'h0, 16'h0000, a);
      check_flag(cnt_req, 1'h1);
      check_vec(SW'(cnt_loc), SW'(loc));
      check_flag(stall, 1'h1);
      drive(1'h0, 16'h0000, a);
      check_flag(stall, 1'h1);
      drive(1'h0, 16'h0000, a);
      check_flag(stall, 1'h0);
      check_flag(loop_active, 1'h1);
      check_vec(SW'(remaining), SW'(loc));
   endtask : start_loop
   // Fetch walks every pass in order up to the end label, never branching inside
   task automatic run_loop(input logic [AW-1:0] s, input logic [AW-1:0] e, input int n);
      for (int k = n; k >= 0; k--)
      begin
         for (logic [AW-1:0] a = s; a <= e; a++)
         begin
            @(negedge clock);
            fetch_valid = 1'h1;
            fetch_addr = a;
            #1 check_vec(SW'(remaining), SW'(k));
            check_flag(redirect, (a == e) && (k != 0));
         end
         check_vec(SW'(redirect_addr), SW'(s));
      end
      @(negedge clock);
      fetch_valid = 1'h0;
      #1 check_flag(loop_active, 1'h0);
   endtask : run_loop
   // ******************************
   // Sequence
   // ******************************
   initial
   begin
      repeat (16) @(posedge clock);
      @(negedge clock) nrst = 1'h1;
      #1 check_vec(SW'({loop_active, loop_shadow, stall, remaining}), '0);
      foreach (rows[i])
      begin
         drive(rows[i].v, rows[i].w, 22'h40);
         check_flag(push_valid, rows[i].push);
         check_flag(pop_req, rows[i].pop);
         check_flag(flags_hold, rows[i].hold);
      end
      start_loop(22'h100, 7'h09, 8'h03);
      run_loop(22'h102, 22'h10b, 3);
      start_loop(22'h201, 7'h08, 8'h05);
      pulse(1'h0);
      drive(1'h1, OP_SAVE, 22'h300);
      check_flag(loop_shadow, 1'h1);
      check_flag(loop_active, 1'h0);
      check_vec(push_data, {7'h08, 16'h0005, 22'h203, 1'h1, 1'h0});
      // Handler runs a repeat of its own, so the restore has real state to undo
      start_loop(22'h310, 7'h09, 8'h02);
      run_loop(22'h312, 22'h31b, 2);
      drive(1'h1, OP_RESTORE, 22'h301);
      check_flag(pop_req, 1'h1);
      drive(1'h0, 16'h0000, 22'h0);
      check_vec(SW'({loop_shadow, loop_active}), SW'(2'h2));
      check_vec(SW'(remaining), SW'(16'h0005));
      check_vec(SW'(redirect_addr), SW'(22'h203));
      pulse(1'h1);
      check_vec(SW'({loop_shadow, loop_active}), SW'(2'h1));
      run_loop(22'h203, 22'h20b, 5);
      drive(1'h1, 16'hb508, 22'h400);
      drive(1'h1, 16'h0105, 22'h401);
      drive(1'h0, 16'h0000, 22'h0);
      check_flag(cnt_req, 1'h0);
      check_flag(stall, 1'h0);
      // Reset in mid-loop drops loop, shadow and count at once
      start_loop(22'h500, 7'h09, 8'h07);
      pulse(1'h0);
      @(negedge clock) nrst = 1'h0;
      #1 check_vec(SW'({loop_active, loop_shadow, stall, remaining}), '0);
      @(negedge clock) nrst = 1'h1;
      drive(1'h1, OP_SAVE, 22'h510);
      check_flag(push_valid, 1'h1);
      check_vec(push_data, '0);
      drive(1'h0, 16'h0000, 22'h0);
      give_verdict();
   end
   initial
   begin
      repeat (3000) @(posedge clock);
      mismatches++;
      give_verdict();
   end
endmodule : testbench
